// >>> hw/scsg_cfg.svh
// Constants for the system clock and sleep gating controller
`ifndef SCSG_CFG_SVH
`define SCSG_CFG_SVH
// Register addresses
`define SCSG_ADDR_LOCK_STATUS   8'h50
`define SCSG_ADDR_RUN_CFG       8'h60
`define SCSG_ADDR_PLL_XLATE     8'h64
`define SCSG_ADDR_RUN_CFG_EXT   8'h70
`define SCSG_ADDR_RUN_GATE      8'h80
`define SCSG_ADDR_SLEEP_GATE    8'h84
`define SCSG_ADDR_DSLEEP_GATE   8'h88
`define SCSG_ADDR_DSLEEP_CLK    8'h8C
// Field positions
`define SCSG_BIT_LOCK           0
`define SCSG_BIT_BYPASS         11
`define SCSG_BIT_PWRDN          13
`define SCSG_BIT_USESYS         22
`define SCSG_BIT_AUTOGATE       27
`define SCSG_BIT_USE_EXT        31
`define SCSG_CRYSTAL_SELECT_LSB           6
`define SCSG_OSC_LSB            4
`define SCSG_DIV_LSB            23
`define SCSG_DSCLK_LSB          4
// Reset values
`define SCSG_RST_RUN_CFG        32'h07A03AD1
`define SCSG_RST_RUN_CFG_EXT    32'h07802800
`define SCSG_RST_RUN_GATE       32'h00000040
`define SCSG_RST_DSLEEP_CLK     32'h07800000
// Lock wait start value
`define SCSG_LOCK_START         16'h1200
// Forced divider in deep sleep
`define SCSG_DS_DIV_BASIC       6'h0F
`define SCSG_DS_DIV_EXT         6'h3F
`endif

// >>> hw/scsg_pkg.sv
// Types for the system clock and sleep gating controller
package scsg_pkg;
  typedef enum logic [2:0] {
    SCSG_SRC_FAST_OSC, SCSG_SRC_FAST_DIV4, SCSG_SRC_MAIN_OSC, SCSG_SRC_SLOW_OSC, SCSG_SRC_PLL
  } scsg_src_t;
  typedef struct packed {
    scsg_src_t  source;
    logic [5:0] divider;
    logic       use_divider;
    logic       pll_on;
    logic       main_osc_on;
  } scsg_clk_sel_t;
endpackage

// >>> hw/scsg_ctrl.sv
// System clock selection, PLL lock wait and sleep-mode clock gating
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "scsg_cfg.svh"
module scsg_ctrl #(
  parameter int GATE_W = 32
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Core sleep handshake
  input  wire logic              wait_for_interrupt_instr,
  input  wire logic              deep_sleep_enable,
  input  wire logic              irq_pending,
  // Main oscillator tick for the lock counter
  input  wire logic              main_osc_tick,
  // Clock selection and gating outputs
  output scsg_pkg::scsg_clk_sel_t clk_sel,
  output logic                   fast_osc_on,
  output logic                   slow_osc_on,
  output logic                   core_clk_en,
  output logic [GATE_W-1:0]      periph_clk_en,
  output logic [31:0]            pll_translation,
  output logic                   pll_lock_raw_flag
);
  // ************************************************************
  // Types and state
  // ************************************************************
  typedef enum logic [1:0] {SCSG_RUN, SCSG_SLEEP, SCSG_DSLEEP, SCSG_WAKE} scsg_mode_t;

  logic [31:0]      run_clock_config, next_run_clock_config;
  logic [31:0]      run_clock_config_ext, next_run_clock_config_ext;
  logic [GATE_W-1:0] run_gating_regs, next_run_gating_regs;
  logic [GATE_W-1:0] sleep_gating_regs, next_sleep_gating_regs;
  logic [GATE_W-1:0] deep_sleep_gating_regs, next_deep_sleep_gating_regs;
  logic [31:0]      deep_sleep_clock_cfg, next_deep_sleep_clock_cfg;
  logic [15:0]      lock_count, next_lock_count;
  logic             lock_flag, next_lock_flag;
  scsg_mode_t       mode, next_mode;
  logic [31:0]      rdata, next_rdata;
  scsg_pkg::scsg_clk_sel_t sel_q, next_sel;

  // ************************************************************
  // Effective configuration
  // ************************************************************
  logic       use_ext;
  logic       bypass, pwrdn, usesys, autogate;
  logic [1:0] osc_src;
  logic [5:0] system_divider;
  logic [3:0] crystal_select;
  logic       relock;

  always_comb begin
    use_ext  = run_clock_config_ext[`SCSG_BIT_USE_EXT];
    autogate = run_clock_config[`SCSG_BIT_AUTOGATE];
    usesys   = run_clock_config[`SCSG_BIT_USESYS];
    crystal_select = run_clock_config[`SCSG_CRYSTAL_SELECT_LSB +: 4];
    if (use_ext) begin
      bypass  = run_clock_config_ext[`SCSG_BIT_BYPASS];
      pwrdn   = run_clock_config_ext[`SCSG_BIT_PWRDN];
      osc_src = run_clock_config_ext[`SCSG_OSC_LSB +: 2];
      system_divider  = run_clock_config_ext[`SCSG_DIV_LSB +: 6];
    end else begin
      bypass  = run_clock_config[`SCSG_BIT_BYPASS];
      pwrdn   = run_clock_config[`SCSG_BIT_PWRDN];
      osc_src = run_clock_config[`SCSG_OSC_LSB +: 2];
      system_divider  = {2'h0, run_clock_config[`SCSG_DIV_LSB +: 4]};
    end
  end

  // Crystal number to PLL multiplier/divider, fixed in hardware
  // Registered from the next config so it never lags the crystal field
  logic [31:0] xlate_q, next_xlate;
  always_comb begin
    next_xlate = {18'h0, 5'h0, 5'(next_run_clock_config[`SCSG_CRYSTAL_SELECT_LSB +: 4]) + 5'h01, 4'h0};
  end

  // ************************************************************
  // Registers and lock counter
  // ************************************************************
  logic crystal_select_wr_change, pwrup_edge, pwrdn_wr;
  always_comb begin
    // Rewriting the same crystal number leaves a running lock wait alone
    crystal_select_wr_change = reg_wr && reg_addr == `SCSG_ADDR_RUN_CFG &&
                     reg_wdata[`SCSG_CRYSTAL_SELECT_LSB +: 4] != crystal_select;
    // Judged on next values: turning the extended register on can also wake the PLL
    if (next_run_clock_config_ext[`SCSG_BIT_USE_EXT])
      pwrdn_wr = next_run_clock_config_ext[`SCSG_BIT_PWRDN];
    else
      pwrdn_wr = next_run_clock_config[`SCSG_BIT_PWRDN];
    pwrup_edge = pwrdn && !pwrdn_wr;
    relock = crystal_select_wr_change || pwrup_edge;
  end

  always_comb begin
    next_run_clock_config       = run_clock_config;
    next_run_clock_config_ext   = run_clock_config_ext;
    next_run_gating_regs        = run_gating_regs;
    next_sleep_gating_regs      = sleep_gating_regs;
    next_deep_sleep_gating_regs = deep_sleep_gating_regs;
    next_deep_sleep_clock_cfg   = deep_sleep_clock_cfg;
    next_rdata                  = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        `SCSG_ADDR_RUN_CFG:     next_run_clock_config = reg_wdata;
        `SCSG_ADDR_RUN_CFG_EXT: next_run_clock_config_ext = reg_wdata;
        `SCSG_ADDR_RUN_GATE:    next_run_gating_regs = reg_wdata[GATE_W-1:0];
        `SCSG_ADDR_SLEEP_GATE:  next_sleep_gating_regs = reg_wdata[GATE_W-1:0];
        `SCSG_ADDR_DSLEEP_GATE: next_deep_sleep_gating_regs = reg_wdata[GATE_W-1:0];
        `SCSG_ADDR_DSLEEP_CLK:  next_deep_sleep_clock_cfg = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `SCSG_ADDR_LOCK_STATUS: next_rdata = {31'h0, lock_flag};
        `SCSG_ADDR_RUN_CFG:     next_rdata = run_clock_config;
        `SCSG_ADDR_PLL_XLATE:   next_rdata = pll_translation;
        `SCSG_ADDR_RUN_CFG_EXT: next_rdata = run_clock_config_ext;
        `SCSG_ADDR_RUN_GATE:    next_rdata = 32'(run_gating_regs);
        `SCSG_ADDR_SLEEP_GATE:  next_rdata = 32'(sleep_gating_regs);
        `SCSG_ADDR_DSLEEP_GATE: next_rdata = 32'(deep_sleep_gating_regs);
        `SCSG_ADDR_DSLEEP_CLK:  next_rdata = deep_sleep_clock_cfg;
        default:                next_rdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    next_lock_count = lock_count;
    next_lock_flag  = lock_flag;
    if (relock) begin
      next_lock_count = `SCSG_LOCK_START;
      next_lock_flag  = 1'b0;
    end else if (main_osc_tick && lock_count != 16'h0) begin
      next_lock_count = lock_count - 16'h1;
      if (lock_count == 16'h1 && !pwrdn)
        next_lock_flag = 1'b1;
    end
    // Powered-down PLL drops its lock flag one cycle after pwrdn is set; power-up relocks anyway
    if (pwrdn)
      next_lock_flag = 1'b0;
  end

  // ************************************************************
  // Mode machine and clock selection
  // ************************************************************
  // Run-mode selection, also what sleep keeps unchanged
  scsg_pkg::scsg_clk_sel_t run_sel;
  logic pll_usable;
  always_comb begin
    pll_usable = !pwrdn && lock_flag;
    run_sel.pll_on      = !pwrdn;
    run_sel.main_osc_on = 1'b1;
    run_sel.divider     = system_divider;
    run_sel.use_divider = usesys && !bypass;
    case (osc_src)
      2'h0:    run_sel.source = scsg_pkg::SCSG_SRC_MAIN_OSC;
      2'h1:    run_sel.source = scsg_pkg::SCSG_SRC_FAST_OSC;
      2'h2:    run_sel.source = scsg_pkg::SCSG_SRC_FAST_DIV4;
      default: run_sel.source = scsg_pkg::SCSG_SRC_SLOW_OSC;
    endcase
    if (!bypass && pll_usable)
      run_sel.source = scsg_pkg::SCSG_SRC_PLL;
    if (bypass)
      run_sel.use_divider = 1'b0;
  end

  logic [1:0] ds_osc;
  always_comb begin
    ds_osc    = deep_sleep_clock_cfg[`SCSG_DSCLK_LSB +: 2];
    next_mode = mode;
    next_sel  = sel_q;
    case (mode)
      SCSG_RUN: begin
        next_sel = run_sel;
        if (wait_for_interrupt_instr && !irq_pending) begin
          next_mode = deep_sleep_enable ? SCSG_DSLEEP : SCSG_SLEEP;
          if (deep_sleep_enable) begin
            if (ds_osc != 2'h0) begin
              next_sel.main_osc_on = 1'b0;
              next_sel.source = (ds_osc == 2'h1) ? scsg_pkg::SCSG_SRC_FAST_OSC : scsg_pkg::SCSG_SRC_SLOW_OSC;
            end else begin
              // Main oscillator is the deep-sleep default, whatever Run used
              next_sel.source = scsg_pkg::SCSG_SRC_MAIN_OSC;
            end
            if (run_sel.pll_on) begin
              next_sel.pll_on      = 1'b0;
              next_sel.use_divider = 1'b1;
              next_sel.divider     = use_ext ? `SCSG_DS_DIV_EXT : `SCSG_DS_DIV_BASIC;
            end
          end
        end
      end
      SCSG_SLEEP: begin
        next_sel = run_sel;
        if (irq_pending)
          next_mode = SCSG_RUN;
      end
      SCSG_DSLEEP: begin
        if (irq_pending) begin
          next_sel  = run_sel;
          next_mode = SCSG_WAKE;
        end
      end
      SCSG_WAKE: begin
        // Clock restored one cycle before core clocks come back
        next_sel  = run_sel;
        next_mode = SCSG_RUN;
      end
      default: next_mode = SCSG_RUN;
    endcase
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    core_clk_en = (mode == SCSG_RUN);
    fast_osc_on = (sel_q.source == scsg_pkg::SCSG_SRC_FAST_OSC) ||
                  (sel_q.source == scsg_pkg::SCSG_SRC_FAST_DIV4);
    slow_osc_on = (sel_q.source == scsg_pkg::SCSG_SRC_SLOW_OSC);
    case (mode)
      SCSG_RUN:    periph_clk_en = run_gating_regs;
      SCSG_SLEEP:  periph_clk_en = autogate ? sleep_gating_regs : run_gating_regs;
      SCSG_DSLEEP: periph_clk_en = autogate ? deep_sleep_gating_regs : run_gating_regs;
      default:     periph_clk_en = '0;
    endcase
    clk_sel           = sel_q;
    reg_rdata         = rdata;
    pll_translation   = xlate_q;
    pll_lock_raw_flag = lock_flag;
  end

  // ************************************************************
  // State registers
  // ************************************************************
  // Reset branch holds constants only; translation resets to the reset crystal
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run_clock_config       <= `SCSG_RST_RUN_CFG;
      run_clock_config_ext   <= `SCSG_RST_RUN_CFG_EXT;
      run_gating_regs        <= GATE_W'(`SCSG_RST_RUN_GATE);
      sleep_gating_regs      <= GATE_W'(`SCSG_RST_RUN_GATE);
      deep_sleep_gating_regs <= GATE_W'(`SCSG_RST_RUN_GATE);
      deep_sleep_clock_cfg   <= `SCSG_RST_DSLEEP_CLK;
      lock_count             <= 16'h0;
      lock_flag              <= 1'b0;
      mode                   <= SCSG_RUN;
      rdata                  <= 32'h0;
      xlate_q                <= {18'h0, 5'h0, 5'(4'(`SCSG_RST_RUN_CFG >> `SCSG_CRYSTAL_SELECT_LSB)) + 5'h01, 4'h0};
      sel_q                  <= '{source: scsg_pkg::SCSG_SRC_FAST_OSC, divider: 6'h0,
                                  use_divider: 1'b0, pll_on: 1'b0, main_osc_on: 1'b1};
    end else begin
      run_clock_config       <= next_run_clock_config;
      run_clock_config_ext   <= next_run_clock_config_ext;
      run_gating_regs        <= next_run_gating_regs;
      sleep_gating_regs      <= next_sleep_gating_regs;
      deep_sleep_gating_regs <= next_deep_sleep_gating_regs;
      deep_sleep_clock_cfg   <= next_deep_sleep_clock_cfg;
      lock_count             <= next_lock_count;
      lock_flag              <= next_lock_flag;
      mode                   <= next_mode;
      rdata                  <= next_rdata;
      xlate_q                <= next_xlate;
      sel_q                  <= next_sel;
    end
  end
endmodule // scsg_ctrl

// >>> verification/scsg_ctrl_props.sv
// Port assertions for the system clock and sleep gating controller
`timescale 1ns/1ns
module scsg_ctrl_props #(
  parameter int GATE_W = 32
) (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    arst_n,
  // Core side
  input wire logic                    wait_for_interrupt_instr,
  input wire logic                    deep_sleep_enable,
  input wire logic                    irq_pending,
  input wire logic                    main_osc_tick,
  // Clock outputs
  input wire scsg_pkg::scsg_clk_sel_t clk_sel,
  input wire logic                    fast_osc_on,
  input wire logic                    core_clk_en,
  input wire logic [GATE_W-1:0]       periph_clk_en,
  input wire logic                    pll_lock_raw_flag
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Selection may leave the PLL one edge after the flag drops, hence the one-cycle slack
  a_pll_lock_gate: assert property (clk_sel.source == scsg_pkg::SCSG_SRC_PLL |->
    pll_lock_raw_flag || $past(pll_lock_raw_flag)) else $error("PLL selected while unlocked");
  a_pll_off_out: assert property (!clk_sel.pll_on |-> clk_sel.source != scsg_pkg::SCSG_SRC_PLL)
    else $error("powered-down PLL selected");
  a_core_stops: assert property (core_clk_en && wait_for_interrupt_instr && !irq_pending |=>
    !core_clk_en) else $error("core clock kept after sleep request");
  a_wake_run: assert property (!core_clk_en && irq_pending |-> ##[1:2] core_clk_en)
    else $error("no return to run after interrupt");
  a_lock_on_tick: assert property ($rose(pll_lock_raw_flag) |->
    $past(main_osc_tick) || $past(main_osc_tick, 2)) else $error("lock flag set without a tick");
  a_sleep_keeps: assert property ($fell(core_clk_en) && !$past(deep_sleep_enable) |->
    clk_sel == $past(clk_sel)) else $error("clock changed on sleep entry");
  a_ds_pll_down: assert property ($fell(core_clk_en) && $past(deep_sleep_enable) |-> !clk_sel.pll_on)
    else $error("PLL left running in deep sleep");
  // Only deep sleep has a restore cycle; plain sleep returns at once
  a_wake_gated: assert property ($rose(core_clk_en) && $past(deep_sleep_enable) |->
    $past(periph_clk_en) == '0) else $error("peripherals clocked before the clock was restored");
  a_fast_osc_pwr: assert property (clk_sel.source inside {scsg_pkg::SCSG_SRC_FAST_OSC,
    scsg_pkg::SCSG_SRC_FAST_DIV4} |-> fast_osc_on) else $error("selected fast oscillator is off");
endmodule // scsg_ctrl_props
bind scsg_ctrl scsg_ctrl_props #(.GATE_W(GATE_W)) scsg_ctrl_props_i (.clock, .arst_n, .wait_for_interrupt_instr,
  .deep_sleep_enable, .irq_pending, .main_osc_tick, .clk_sel, .fast_osc_on, .core_clk_en, .periph_clk_en,
  .pll_lock_raw_flag);

// >>> verification/scsg_core_model.sv
// Core-side model: sleep requests, wakeup interrupts, main oscillator ticks
`timescale 1ns/1ns
module scsg_core_model (
  // Clock
  input  wire logic clock,
  // Towards the controller
  output logic      wait_for_interrupt_instr,
  output logic      deep_sleep_enable,
  output logic      irq_pending,
  output logic      main_osc_tick
);
  initial begin
    wait_for_interrupt_instr = 1'b0;
    deep_sleep_enable = 1'b0;
    irq_pending = 1'b0;
    main_osc_tick = 1'b0;
  end
  task automatic sleep_req(input logic deep);
    @(posedge clock);
    deep_sleep_enable <= deep;
    @(posedge clock);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge clock);
    wait_for_interrupt_instr <= 1'b0;
  endtask
  // Held longer, a pending interrupt would block the next entry
  task automatic wake();
    @(posedge clock);
    irq_pending <= 1'b1;
    @(posedge clock);
    irq_pending <= 1'b0;
  endtask
  // Main oscillator slower than the bus clock: one tick every other cycle
  task automatic ticks(input logic [15:0] n);
    repeat (n) begin
      @(posedge clock);
      main_osc_tick <= 1'b1;
      @(posedge clock);
      main_osc_tick <= 1'b0;
    end
  endtask
endmodule // scsg_core_model

// >>> verification/tb.sv
// Self-checking testbench for the system clock and sleep gating controller
`timescale 1ns/1ns
module tb;
  logic                    clock = 1'b0;
  logic                    arst_n = 1'b0;
  logic [7:0]              reg_addr = 8'h00;
  logic [31:0]             reg_wdata = 32'h0;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic                    rd_seen = 1'b0;
  logic [31:0]             reg_rdata, pll_translation, periph_clk_en;
  logic                    wait_for_interrupt_instr, deep_sleep_enable, irq_pending, main_osc_tick;
  logic                    fast_osc_on, slow_osc_on, core_clk_en, pll_lock_raw_flag;
  scsg_pkg::scsg_clk_sel_t clk_sel;
  logic [31:0]             exp_q[$];
  logic [31:0]             seed = 32'h85513F94;
  logic [31:0]             cfg, rg, sg, dg, ds;
  logic                    dp, au;
  logic [3:0]              xt;
  logic [7:0]              ra [7] = '{8'h60, 8'h70, 8'h80, 8'h8C, 8'h50, 8'h44, 8'h64};
  logic [31:0]             rv [7] = '{32'h07A03AD1, 32'h07802800, 32'h40, 32'h07800000, 32'h0, 32'h0, 32'hC0};
  int                      bad_count = 0;
  int                      checks_done = 0;
  always #50 clock = ~clock;
  scsg_ctrl scsg_ctrl_i (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wait_for_interrupt_instr, .deep_sleep_enable, .irq_pending, .main_osc_tick, .clk_sel,
    .fast_osc_on, .slow_osc_on, .core_clk_en, .periph_clk_en, .pll_translation, .pll_lock_raw_flag);
  scsg_core_model scsg_core_model_i (.clock, .wait_for_interrupt_instr, .deep_sleep_enable,
    .irq_pending, .main_osc_tick);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A read notes its expected word; the monitor below compares it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    if (!wr) exp_q.push_back(d);
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  always @(posedge clock) begin
    rd_seen <= reg_rd;
    if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  end
  task automatic lock_wait();
    scsg_core_model_i.ticks(16'h11FF);
    @(negedge clock);
    chk("lock_early", 32'h0, {31'h0, pll_lock_raw_flag});
    chk("pll_early", 32'h0, {31'h0, clk_sel.source == scsg_pkg::SCSG_SRC_PLL});
    scsg_core_model_i.ticks(16'h0001);
    repeat (2) @(negedge clock);
    chk("lock_done", 32'h1, {31'h0, pll_lock_raw_flag});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(60000 * 100);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk("src_reset", 32'h0, {29'h0, clk_sel.source});
    chk("fast_reset", 32'h1, {31'h0, fast_osc_on});
    chk("pll_reset", 32'h0, {31'h0, clk_sel.pll_on});
    chk("gate_reset", 32'h40, periph_clk_en);
    chk("xlate_reset", 32'hC, {27'h0, pll_translation[8:4]});
    bus(1'b1, 8'h44, xs());
    bus(1'b1, 8'h64, xs());
    foreach (ra[i]) bus(1'b0, ra[i], rv[i]);
    cfg = xs();
    xt = {1'b0, cfg[2:0]};
    // Bypass kept on while the PLL settles
    cfg = (32'h07A01AD1 & ~32'h3C0) | {22'h0, xt, 6'h0};
    bus(1'b1, 8'h60, cfg);
    @(negedge clock);
    chk("xlate", {27'h0, 5'(xt) + 5'h01}, {27'h0, pll_translation[8:4]});
    scsg_core_model_i.ticks(16'h0064);
    cfg = cfg ^ 32'h40;
    bus(1'b1, 8'h60, cfg);
    lock_wait();
    bus(1'b0, 8'h50, 32'h1);
    bus(1'b1, 8'h60, cfg);
    @(negedge clock);
    chk("lock_same", 32'h1, {31'h0, pll_lock_raw_flag});
    bus(1'b1, 8'h60, cfg | 32'h2000);
    cfg = cfg & ~32'h800;
    bus(1'b1, 8'h60, cfg);
    lock_wait();
    @(negedge clock);
    chk("pll_sel", 32'h4, {29'h0, clk_sel.source});
    rg = xs();
    sg = xs();
    dg = xs();
    bus(1'b1, 8'h80, rg);
    bus(1'b1, 8'h84, sg);
    bus(1'b1, 8'h88, dg);
    bus(1'b1, 8'h8C, 32'h10);
    bus(1'b0, 8'h80, rg);
    @(negedge clock);
    chk("run_gate", rg, periph_clk_en);
    // Sleep twice, then deep sleep on fast, slow and main oscillator; auto gating off and on
    for (int m = 0; m < 5; m++) begin
      dp = (m > 1);
      au = m[0];
      ds = (m == 2) ? 32'h10 : (m == 3) ? 32'h20 : 32'h0;
      if (m == 3) bus(1'b1, 8'h70, 32'h80000000);
      if (dp) bus(1'b1, 8'h8C, ds);
      bus(1'b1, 8'h60, au ? cfg | 32'h08000000 : cfg);
      scsg_core_model_i.sleep_req(dp);
      @(negedge clock);
      chk("core_en", 32'h0, {31'h0, core_clk_en});
      chk("gate", au ? (dp ? dg : sg) : rg, periph_clk_en);
      if (dp) begin
        chk("ds_src", (m == 2) ? 32'h0 : (m == 3) ? 32'h3 : 32'h2, {29'h0, clk_sel.source});
        chk("ds_osc", {31'h0, m == 4}, {30'h0, clk_sel.pll_on, clk_sel.main_osc_on});
        chk("ds_osc_pwr", {30'h0, m == 3, m == 2}, {30'h0, slow_osc_on, fast_osc_on});
        chk("ds_div", (m == 2) ? 32'hF : 32'h3F, {26'h0, clk_sel.divider});
      end
      else chk("sl_src", 32'h4, {29'h0, clk_sel.source});
      scsg_core_model_i.wake();
      @(negedge clock);
      chk("wake_gate", dp ? 32'h0 : rg, periph_clk_en);
      chk("wake_pll", 32'h1, {31'h0, clk_sel.pll_on});
      chk("wake_core", {31'h0, !dp}, {31'h0, core_clk_en});
      @(negedge clock);
      chk("run_back", 32'h1, {31'h0, core_clk_en});
    end
    final_report();
  end
endmodule // tb
